// *** core/ssl_supervisor.sv ***
// Power-good, reset, overload and self-test supervision of the readout
`timescale 1ns/10ps
`default_nettype none
module ssl_supervisor
   import ssl_pkg::*;
#(
   parameter int START_TICKS = SSL_START_TICKS,
   parameter int TEST_HALF_TICKS = SSL_TEST_HALF_TICKS
)
(
   input wire logic clock,
   input wire logic rst,
   input wire logic supply_above_threshold,
   input wire logic ext_reset_n,
   input wire logic selftest_request,
   input wire logic overload_detect,
   input wire logic [SSL_OUT_W-1:0] accel_sample,
   output logic power_good,
   output logic error_flag,
   output logic readout_reset,
   output logic [SSL_OUT_W-1:0] diff_out_pos,
   output logic [SSL_OUT_W-1:0] diff_out_neg
);
   ssl_state_type state_q;
   ssl_state_type state_d;
   logic tick;
   logic hold_cause;
   logic [SSL_CNT_W-1:0] start_cnt_q;
   logic [SSL_CNT_W-1:0] test_cnt_q;
   logic test_phase_q;
   logic power_good_q;
   logic error_q;
   ssl_diff_type out_q;
   ssl_diff_type out_d;

   ssl_tick_gen ssl_tick_gen_i
   (
      .clock(clock),
      .rst(rst),
      .tick(tick)
   );

   // Any cause that voids the outputs restarts the sequence from scratch
   assign hold_cause = !ext_reset_n || overload_detect;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         SSL_ST_POWER_LOW:
            if (supply_above_threshold)
            begin
               state_d = SSL_ST_STARTUP;
            end
         SSL_ST_STARTUP:
            if (!supply_above_threshold)
            begin
               state_d = SSL_ST_POWER_LOW;
            end
            else if (!hold_cause && tick && start_cnt_q == SSL_CNT_W'(START_TICKS - 1))
            begin
               state_d = SSL_ST_RUN;
            end
         SSL_ST_RUN:
            if (!supply_above_threshold)
            begin
               state_d = SSL_ST_POWER_LOW;
            end
            else if (hold_cause)
            begin
               state_d = SSL_ST_STARTUP;
            end
      endcase
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         state_q <= SSL_ST_POWER_LOW;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   // Count is held at zero while any cause persists, so overload keeps restarting
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         start_cnt_q <= '0;
      end
      else if (state_q != SSL_ST_STARTUP || hold_cause)
      begin
         start_cnt_q <= '0;
      end
      else if (tick)
      begin
         start_cnt_q <= start_cnt_q + 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         power_good_q <= 1'b0;
      end
      else
      begin
         power_good_q <= supply_above_threshold;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         error_q <= 1'b1;
      end
      else
      begin
         error_q <= (state_d != SSL_ST_RUN) || hold_cause;
      end
   end

   // Square wave runs on the tick only while requested, starting from phase zero; the host must hold the part still
   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         test_cnt_q <= '0;
         test_phase_q <= 1'b0;
      end
      else if (!selftest_request)
      begin
         test_cnt_q <= '0;
         test_phase_q <= 1'b0;
      end
      else if (tick)
      begin
         if (test_cnt_q == SSL_CNT_W'(TEST_HALF_TICKS - 1))
         begin
            test_cnt_q <= '0;
            test_phase_q <= !test_phase_q;
         end
         else
         begin
            test_cnt_q <= test_cnt_q + 1'b1;
         end
      end
   end

   always_comb
   begin
      out_d.pos = accel_sample;
      out_d.neg = SSL_OUT_W'(SSL_OUT_MID - (accel_sample - SSL_OUT_MID));
      if (selftest_request)
      begin
         if (test_phase_q)
         begin
            out_d.pos = accel_sample + SSL_OUT_TEST_STEP;
            out_d.neg = out_d.neg - SSL_OUT_TEST_STEP;
         end
         else
         begin
            out_d.pos = accel_sample - SSL_OUT_TEST_STEP;
            out_d.neg = out_d.neg + SSL_OUT_TEST_STEP;
         end
      end
      // Next state, so outputs turn valid in the very cycle the error flag falls
      if (!ext_reset_n || state_d != SSL_ST_RUN)
      begin
         out_d.pos = SSL_OUT_RESET;
         out_d.neg = SSL_OUT_RESET;
      end
   end

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         out_q <= '{pos: SSL_OUT_RESET, neg: SSL_OUT_RESET};
      end
      else
      begin
         out_q <= out_d;
      end
   end

   assign power_good = power_good_q;
   assign error_flag = error_q;
   assign readout_reset = (state_q != SSL_ST_RUN);
   assign diff_out_pos = out_q.pos;
   assign diff_out_neg = out_q.neg;

   chk_pg_follows: assert property (@(posedge clock) disable iff (rst)
      !supply_above_threshold |=> !power_good) else $error("power good high below threshold");
   chk_pg_low_err: assert property (@(posedge clock) disable iff (rst)
      !power_good |-> error_flag) else $error("error low while power good low");
   chk_brownout_restart: assert property (@(posedge clock) disable iff (rst)
      (state_q == SSL_ST_RUN && !supply_above_threshold) |=> state_q == SSL_ST_POWER_LOW)
      else $error("brownout missed");
   chk_err_startup: assert property (@(posedge clock) disable iff (rst)
      (state_q != SSL_ST_RUN) |-> error_flag) else $error("error low before startup done");
   chk_reset_mid: assert property (@(posedge clock) disable iff (rst)
      !ext_reset_n |=> (diff_out_pos == SSL_OUT_RESET && diff_out_neg == SSL_OUT_RESET
      && error_flag)) else $error("reset not forcing midscale");
   chk_overload_err: assert property (@(posedge clock) disable iff (rst)
      overload_detect |=> error_flag && readout_reset) else $error("overload not flagged");
   chk_overload_hold: assert property (@(posedge clock) disable iff (rst)
      (overload_detect && state_q == SSL_ST_STARTUP) |=> start_cnt_q == '0)
      else $error("startup advanced during overload");
   chk_test_idle: assert property (@(posedge clock) disable iff (rst)
      !selftest_request |=> !test_phase_q) else $error("self test phase while idle");
   chk_test_step: assert property (@(posedge clock) disable iff (rst)
      (state_d == SSL_ST_RUN && selftest_request && test_phase_q)
      |=> diff_out_pos == $past(accel_sample) + SSL_OUT_TEST_STEP)
      else $error("self test step missing");
   chk_run_err_low: assert property (@(posedge clock) disable iff (rst)
      (state_q == SSL_ST_RUN && !hold_cause && supply_above_threshold) |=> !error_flag)
      else $error("error high in run");

   cov_reach_run: cover property (@(posedge clock) disable iff (rst) state_q == SSL_ST_RUN);
   cov_brownout: cover property (@(posedge clock) disable iff (rst)
      state_q == SSL_ST_RUN ##1 state_q == SSL_ST_POWER_LOW);
   cov_overload: cover property (@(posedge clock) disable iff (rst)
      state_q == SSL_ST_RUN && overload_detect);
   cov_selftest: cover property (@(posedge clock) disable iff (rst)
      state_q == SSL_ST_RUN && $rose(test_phase_q));
endmodule
`default_nettype wire

// *** core/ssl_pkg.sv ***
// Shared constants and types for the sensor supervisor logic
package ssl_pkg;
   localparam int SSL_CLK_HZ = 125000000;
   localparam int SSL_SEQ_HZ = 200000;
   localparam int SSL_SEQ_DIV = SSL_CLK_HZ / SSL_SEQ_HZ;
   localparam int SSL_TEST_HZ = 24;
   localparam int SSL_TEST_HALF_TICKS = SSL_SEQ_HZ / (2 * SSL_TEST_HZ);
   localparam int SSL_START_TICKS = 1000;
   localparam int SSL_DIV_W = 10;
   localparam int SSL_CNT_W = 16;
   localparam int SSL_OUT_W = 12;
   localparam logic [SSL_OUT_W-1:0] SSL_OUT_MID = 12'h800;
   localparam logic [SSL_OUT_W-1:0] SSL_OUT_TEST_STEP = 12'h0C0;
   localparam logic [SSL_OUT_W-1:0] SSL_OUT_RESET = 12'h800;

   typedef enum logic [1:0] {
      SSL_ST_POWER_LOW,
      SSL_ST_STARTUP,
      SSL_ST_RUN
   } ssl_state_type;

   typedef struct packed {
      logic [SSL_OUT_W-1:0] pos;
      logic [SSL_OUT_W-1:0] neg;
   } ssl_diff_type;
endpackage

// *** core/ssl_tick_gen.sv ***
// Divider that turns the system clock into the 200 kHz sequencing tick
`timescale 1ns/10ps
`default_nettype none
module ssl_tick_gen
   import ssl_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   output logic tick
);
   logic [SSL_DIV_W-1:0] div_q;

   always_ff @(posedge clock)
   begin
      if (rst)
      begin
         div_q <= '0;
      end
      else if (div_q == SSL_DIV_W'(SSL_SEQ_DIV - 1))
      begin
         div_q <= '0;
      end
      else
      begin
         div_q <= div_q + 1'b1;
      end
   end

   assign tick = (div_q == SSL_DIV_W'(SSL_SEQ_DIV - 1));

   chk_tick_period: assert property (@(posedge clock) disable iff (rst)
      tick |=> !tick [*8]) else $error("tick repeats too soon");
endmodule
`default_nettype wire

// *** tb/ssl_host_model.sv ***
// Host controller model driving the reset and self-test pins
`timescale 1ns/10ps
`default_nettype none
module ssl_host_model
(
   input wire logic clock,
   input wire logic do_reset,
   input wire logic do_test,
   input wire logic at_rest,
   output logic ext_reset_n,
   output logic selftest_request
);
   // Idle levels match the pin pulls, so an idle host is harmless
   initial
   begin
      ext_reset_n = 1'b1;
      selftest_request = 1'b0;
      // Pins move just after the edge, as a real host would
      forever
      begin
         @(posedge clock);
         ext_reset_n <= #1 !do_reset;
         selftest_request <= #1 do_test && at_rest;
      end
   end
endmodule
`default_nettype wire

// *** tb/ssl_supervisor_test.sv ***
// Self-checking bench for the sensor supervisor
`timescale 1ns/10ps
`default_nettype none
module ssl_supervisor_test;
   import ssl_pkg::*;
   logic clock, rst, supply, ovl, do_reset, do_test, ext_reset_n, selftest_request;
   logic power_good, error_flag, readout_reset;
   logic [SSL_OUT_W-1:0] accel, pos, neg;
   int fail_count = 0;
   int num_checks = 0;
   // Short self-test half period so the square wave flips within the run
   localparam int TB_HALF_TICKS = 2;
   localparam int TB_HALF_CYC = TB_HALF_TICKS * SSL_SEQ_DIV;
   ssl_supervisor #(.START_TICKS(2), .TEST_HALF_TICKS(TB_HALF_TICKS)) ssl_supervisor_i (
      .clock(clock), .rst(rst),
      .supply_above_threshold(supply), .ext_reset_n(ext_reset_n),
      .selftest_request(selftest_request), .overload_detect(ovl), .accel_sample(accel),
      .power_good(power_good), .error_flag(error_flag), .readout_reset(readout_reset),
      .diff_out_pos(pos), .diff_out_neg(neg));
   ssl_host_model ssl_host_model_i (.clock(clock), .do_reset(do_reset), .do_test(do_test),
      .at_rest(1'b1), .ext_reset_n(ext_reset_n), .selftest_request(selftest_request));
   task automatic end_sim;
      if (fail_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Startup of two ticks takes at most about 1300 clocks
   task automatic wait_err(input logic val, input int max);
      int i;
      i = 0;
      while (error_flag !== val && i < max)
      begin
         cyc(1);
         i++;
      end
      chk(error_flag === val, "error flag did not settle");
   endtask
   task automatic t_powerup;
      chk(power_good === 1'b0 && error_flag === 1'b1, "bad idle flags");
      chk(pos === SSL_OUT_RESET && neg === SSL_OUT_RESET, "outputs not mid");
      supply = 1'b1;
      cyc(2);
      chk(power_good === 1'b1, "power good not high");
      cyc(600);
      chk(error_flag === 1'b1, "startup ended early");
      wait_err(1'b0, 2000);
   endtask
   task automatic t_track;
      accel = 12'h900;
      cyc(3);
      chk(pos === 12'h900 && neg === 12'h700, "outputs not tracking");
   endtask
   task automatic t_ext_reset;
      do_reset = 1'b1;
      cyc(4);
      chk(error_flag === 1'b1 && pos === 12'h800 && neg === 12'h800, "reset bad");
      do_reset = 1'b0;
      wait_err(1'b0, 2000);
   endtask
   task automatic t_overload;
      ovl = 1'b1;
      cyc(3);
      chk(error_flag === 1'b1 && readout_reset === 1'b1, "overload missed");
      chk(pos === 12'h800 && neg === 12'h800, "overload outputs");
      cyc(3000);
      chk(error_flag === 1'b1, "overload ended early");
      ovl = 1'b0;
      wait_err(1'b0, 2000);
   endtask
   task automatic t_brownout;
      supply = 1'b0;
      cyc(2);
      chk(power_good === 1'b0 && error_flag === 1'b1, "brownout missed");
      supply = 1'b1;
      cyc(600);
      chk(error_flag === 1'b1, "no fresh startup");
      wait_err(1'b0, 2000);
   endtask
   task automatic t_selftest;
      int n;
      n = 0;
      accel = 12'h800;
      do_test = 1'b1;
      cyc(4);
      chk(pos === 12'h740 && neg === 12'h8C0, "no test step");
      while (pos !== 12'h8C0 && n < 4 * TB_HALF_CYC)
      begin
         cyc(1);
         n++;
      end
      chk(pos === 12'h8C0 && neg === 12'h740, "test step not inverted");
      n = 0;
      while (pos !== 12'h740 && n < 4 * TB_HALF_CYC)
      begin
         cyc(1);
         n++;
      end
      chk(n == TB_HALF_CYC, "test half period wrong");
      do_test = 1'b0;
      cyc(4);
      chk(pos === 12'h800 && neg === 12'h800, "test step stuck");
   endtask
   initial
   begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   // Whole run is near 10000 clocks; this limit is well beyond
   initial
   begin
      #400000;
      fail_count++;
      end_sim();
   end
   initial
   begin
      rst = 1'b1;
      supply = 1'b0;
      ovl = 1'b0;
      do_reset = 1'b0;
      do_test = 1'b0;
      accel = 12'h800;
      cyc(16);
      rst = 1'b0;
      cyc(2);
      t_powerup();
      t_track();
      t_ext_reset();
      t_overload();
      t_brownout();
      t_selftest();
      end_sim();
   end
endmodule
`default_nettype wire
